//--- rtl/ffr_consts.svh
/*
 Constants for the fault flag response controller: command codes,
 field positions, reset values and timing. Assumes an 8-bit data port.
*/
`ifndef FFR_CONSTS_SVH
`define FFR_CONSTS_SVH
// ==========================================
// Command codes
`define FFR_A_OUT_OV 16'h0041
`define FFR_A_OUT_UV 16'h0045
`define FFR_A_OT 16'h0050
`define FFR_A_IN_OV 16'h0056
`define FFR_A_IN_UV 16'h005a
`define FFR_A_IN_OC 16'h005c
`define FFR_A_ST_VOUT 16'h007a
`define FFR_A_ST_IN 16'h007c
`define FFR_A_ST_TEMP 16'h007d
`define FFR_A_PCL 16'hfe00
`define FFR_A_PIN_OV 16'hfe01
`define FFR_A_OPEN_LOOP 16'hfe02
// ==========================================
// Response field layout
`define FFR_TYPE_HI 7
`define FFR_TYPE_LO 6
`define FFR_RETRY_HI 5
`define FFR_RETRY_LO 3
`define FFR_DELAY_HI 2
`define FFR_DELAY_LO 0
`define FFR_SWCYC_HI 5
`define FFR_SWCYC_LO 4
`define FFR_ACT_RST 8'h00
// ==========================================
// Timing and thresholds
`define FFR_CLK_NS 10
`define FFR_DELAY_STEP_NS 10000
`define FFR_DELAY_STEP_CYC (`FFR_DELAY_STEP_NS / `FFR_CLK_NS)
`define FFR_OPEN_LOOP_MV 100
`define FFR_OPEN_LOOP_CODE 13'h010e
`endif

//--- rtl/ffr_pkg.sv
/*
 Types of the fault flag response controller.
 Defines NSRC and NSTD itself and does not use ffr_consts.svh.
*/
package ffr_pkg;
    // ==========================================
    // Types and source counts
    typedef enum logic [1:0] {
        RESP_IGNORE = 2'h0,
        RESP_RETRY_DEB = 2'h1,
        RESP_RETRY = 2'h2,
        RESP_DISABLE = 2'h3
    } ffr_resp_t;
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_DELAY = 5'h02,
        ST_WAITSW = 5'h04,
        ST_LATCH = 5'h08,
        ST_HOLD = 5'h10
    } ffr_state_t;
    localparam int NSRC = 9;
    localparam int NSTD = 6;
endpackage : ffr_pkg

//--- rtl/ffr_ctrl.sv
/*
 Fault status and response controller of a power-factor controller.
 Assumes comparator and pin flags arrive asynchronously, sense codes and
 the switching-cycle pulse come from logic on sys_clk, and the host
 reaches the registers through the command port at printed codes.
*/
`timescale 1ns/1ns
`include "ffr_consts.svh"
// Notes on behaviour
// - Output over/under voltage status bits follow limits
// - Input status reports line over/undervoltage
// - Line below turn-off sets bit, shuts down
// - Input overcurrent fault/warning and overpower status
// - Temperature fault and warning status bits
// - Six response registers: type, retry, delay
// - Type 00 ignores fault, supply runs
// - Types 01/10 shut down, retry; 01 debounces
// - Type 11 disables output until flag clears
// - Highest response type wins among concurrent faults
// - Lower fault served after higher one clears
// - Equal type: smallest retry setting wins
// - Pulse current limit always terminates PWM pulse
// - Pulse limit 01: restart after overcurrent delay
// - Pulse limit 10: wait cycles, off until request
// - Pulse limit 11: wait cycles, disable until clear
// - Pin OV/open loop 01: restart after OV delay
// - Pin OV/open loop 10 latch off; 00 ignore
// - Pin OV/open loop 11 disable until clear
// - Open loop when sense differs over 100 mV
// - Summary overvoltage is status OR pin flag
module ffr_ctrl #(
    parameter logic [15:0] DELAY_STEP_CYC = 16'(`FFR_DELAY_STEP_CYC)
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic outOvFaultIn,
    input wire logic outOvWarnIn,
    input wire logic outUvWarnIn,
    input wire logic outUvFaultIn,
    input wire logic lineOvFaultIn,
    input wire logic lineUvWarnIn,
    input wire logic lineUvFaultIn,
    input wire logic input_below_turnoff,
    input wire logic inOcFaultIn,
    input wire logic inOcWarnIn,
    input wire logic inOpWarnIn,
    input wire logic otFaultIn,
    input wire logic otWarnIn,
    input wire logic current_limit_pin,
    input wire logic pinOvIn,
    input wire logic power_on_request,
    input wire logic [11:0] ovSenseCode,
    input wire logic [11:0] feedback_sense_pin,
    input wire logic switchCycleStart,
    input wire logic [15:0] cmdAddr,
    input wire logic cmdWrite,
    input wire logic cmdRead,
    input wire logic [7:0] cmdWrData,
    output logic [7:0] cmdRdData,
    output logic pwmTerminate,
    output logic pwmDisable,
    output logic supplyOff,
    output logic softStartReq,
    output logic summaryOutOv,
    output logic line_good_flag,
    output logic open_loop_flag
);
    import ffr_pkg::*;

    typedef struct packed {
        logic [15:0] syncA;
        logic [15:0] syncB;
        logic pwrOnPrev;
        logic [NSRC-1:0][7:0] act;
        logic [NSTD-1:0][15:0] deb;
        logic [7:0] statVout;
        logic [7:0] statIn;
        logic [7:0] statTemp;
        ffr_state_t state;
        logic [3:0] src;
        logic [15:0] cnt;
        logic [2:0] retries;
        logic [7:0] rdData;
        logic pwmTerm;
        logic pwmOff;
        logic off;
        logic softStart;
        logic sumOv;
        logic lineGood;
        logic openLoop;
    } ffr_regs_t;

    ffr_regs_t r_ff;
    ffr_regs_t nxt_r;

    // ==========================================
    // Combinational helpers
    logic [15:0] rawPins;
    logic [NSRC-1:0] raw;
    logic [NSRC-1:0] eff;
    logic [3:0] best;
    logic found;
    logic pwrOnRise;
    logic [12:0] diff;

    // Asynchronous flags gathered for the two-stage synchroniser
    assign rawPins = {power_on_request, pinOvIn, current_limit_pin, otWarnIn, otFaultIn,
                      inOpWarnIn, inOcWarnIn, inOcFaultIn, input_below_turnoff,
                      lineUvFaultIn, lineUvWarnIn, lineOvFaultIn, outUvFaultIn,
                      outUvWarnIn, outOvWarnIn, outOvFaultIn};
    assign pwrOnRise = r_ff.syncB[15] & ~r_ff.pwrOnPrev;
    // Response sources in register order, then the three fast flags
    assign raw = {r_ff.openLoop, r_ff.syncB[14], r_ff.syncB[13], r_ff.syncB[8],
                  r_ff.syncB[6], r_ff.syncB[4], r_ff.syncB[11], r_ff.syncB[3],
                  r_ff.syncB[0]};
    // Signed distance between the two sense codes
    assign diff = 13'({1'b0, ovSenseCode}) - 13'({1'b0, feedback_sense_pin});

    function automatic logic [15:0] delayCyc(input logic [7:0] a);
        delayCyc = 16'(a[`FFR_DELAY_HI:`FFR_DELAY_LO] * DELAY_STEP_CYC);
    endfunction : delayCyc

    // Qualified flags and priority pick
    always_comb begin
        logic [1:0] bT;
        logic [2:0] bR;
        logic [1:0] t;
        logic [2:0] rt;
        t = 2'h0;
        rt = 3'h0;
        bT = 2'h0;
        bR = 3'h7;
        best = 4'h0;
        found = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            t = r_ff.act[i][`FFR_TYPE_HI:`FFR_TYPE_LO];
            rt = (i < NSTD) ? r_ff.act[i][`FFR_RETRY_HI:`FFR_RETRY_LO] : 3'h0;
            // Type 01 on a standard fault only counts once debounced
            if (i < NSTD && t == RESP_RETRY_DEB) begin
                eff[i] = raw[i] && (r_ff.deb[i] >= delayCyc(r_ff.act[i]));
            end else begin
                eff[i] = raw[i] && (t != RESP_IGNORE);
            end
            if (eff[i] && (t > bT || (t == bT && rt < bR))) begin
                bT = t;
                bR = rt;
                best = 4'(i);
                found = 1'b1;
            end
        end
    end

    // Next-state logic for every register of the block
    always_comb begin
        logic [1:0] t;
        t = r_ff.act[r_ff.src][`FFR_TYPE_HI:`FFR_TYPE_LO];
        nxt_r = r_ff;
        nxt_r.syncA = rawPins;
        nxt_r.syncB = r_ff.syncA;
        nxt_r.pwrOnPrev = r_ff.syncB[15];
        nxt_r.softStart = 1'b0;
        // Debounce counters saturate so a long fault never wraps back
        for (int i = 0; i < NSTD; i++) begin
            if (!raw[i]) begin
                nxt_r.deb[i] = 16'h0000;
            end else if (r_ff.deb[i] != 16'hffff) begin
                nxt_r.deb[i] = r_ff.deb[i] + 16'h0001;
            end
        end
        // Live status bits
        nxt_r.statVout = {r_ff.syncB[0], r_ff.syncB[1], r_ff.syncB[2],
                          r_ff.syncB[3], 4'h0};
        nxt_r.statIn = {r_ff.syncB[4], 1'b0, r_ff.syncB[5], r_ff.syncB[6],
                        r_ff.syncB[7],
                        r_ff.syncB[8], r_ff.syncB[9], r_ff.syncB[10]};
        nxt_r.statTemp = {r_ff.syncB[11], r_ff.syncB[12], 6'h00};
        nxt_r.pwmTerm = r_ff.syncB[13];
        nxt_r.sumOv = r_ff.syncB[0] | r_ff.syncB[14];
        nxt_r.lineGood = ~r_ff.syncB[7];
        // Magnitude beyond the threshold in either direction
        nxt_r.openLoop = diff[12] ? ((~diff + 13'h0001) > `FFR_OPEN_LOOP_CODE)
                                  : (diff > `FFR_OPEN_LOOP_CODE);
        // Host writes and registered reads
        if (cmdWrite) begin
            unique case (cmdAddr)
                `FFR_A_OUT_OV: nxt_r.act[0] = cmdWrData;
                `FFR_A_OUT_UV: nxt_r.act[1] = cmdWrData;
                `FFR_A_OT: nxt_r.act[2] = cmdWrData;
                `FFR_A_IN_OV: nxt_r.act[3] = cmdWrData;
                `FFR_A_IN_UV: nxt_r.act[4] = cmdWrData;
                `FFR_A_IN_OC: nxt_r.act[5] = cmdWrData;
                `FFR_A_PCL: nxt_r.act[6] = cmdWrData;
                `FFR_A_PIN_OV: nxt_r.act[7] = cmdWrData;
                `FFR_A_OPEN_LOOP: nxt_r.act[8] = cmdWrData;
                default: ;
            endcase
        end
        if (cmdRead) begin
            unique case (cmdAddr)
                `FFR_A_OUT_OV: nxt_r.rdData = r_ff.act[0];
                `FFR_A_OUT_UV: nxt_r.rdData = r_ff.act[1];
                `FFR_A_OT: nxt_r.rdData = r_ff.act[2];
                `FFR_A_IN_OV: nxt_r.rdData = r_ff.act[3];
                `FFR_A_IN_UV: nxt_r.rdData = r_ff.act[4];
                `FFR_A_IN_OC: nxt_r.rdData = r_ff.act[5];
                `FFR_A_PCL: nxt_r.rdData = r_ff.act[6];
                `FFR_A_PIN_OV: nxt_r.rdData = r_ff.act[7];
                `FFR_A_OPEN_LOOP: nxt_r.rdData = r_ff.act[8];
                `FFR_A_ST_VOUT: nxt_r.rdData = r_ff.statVout;
                `FFR_A_ST_IN: nxt_r.rdData = r_ff.statIn;
                `FFR_A_ST_TEMP: nxt_r.rdData = r_ff.statTemp;
                default: nxt_r.rdData = 8'h00;
            endcase
        end
        // Response sequencer
        unique case (r_ff.state)
            ST_RUN: begin
                if (!found) begin
                    nxt_r.retries = 3'h0;
                end else begin
                    nxt_r.src = best;
                    t = r_ff.act[best][`FFR_TYPE_HI:`FFR_TYPE_LO];
                    if (best >= 4'(NSTD)) begin
                        if (t == RESP_RETRY_DEB) begin
                            nxt_r.state = ST_DELAY;
                            nxt_r.cnt = delayCyc(best == 4'h6 ? r_ff.act[5] : r_ff.act[0]);
                        end else if (best == 4'h6) begin
                            nxt_r.state = ST_WAITSW;
                            nxt_r.cnt = {14'h0000,
                                         r_ff.act[6][`FFR_SWCYC_HI:`FFR_SWCYC_LO]};
                        end else begin
                            nxt_r.state = (t == RESP_RETRY) ? ST_LATCH : ST_HOLD;
                        end
                    end else if (t == RESP_DISABLE) begin
                        nxt_r.state = ST_HOLD;
                    end else if (r_ff.retries <
                                 r_ff.act[best][`FFR_RETRY_HI:`FFR_RETRY_LO]) begin
                        nxt_r.state = ST_DELAY;
                        nxt_r.cnt = delayCyc(r_ff.act[best]);
                        nxt_r.retries = r_ff.retries + 3'h1;
                    end else begin
                        nxt_r.state = ST_LATCH;
                    end
                end
            end
            ST_DELAY: begin
                if (r_ff.cnt != 16'h0000) begin
                    nxt_r.cnt = r_ff.cnt - 16'h0001;
                end else if (!r_ff.syncB[7]) begin
                    nxt_r.softStart = 1'b1;
                    nxt_r.state = ST_RUN;
                end
            end
            ST_WAITSW: begin
                // Flag gone before the count ran out: nothing to do
                if (!raw[r_ff.src]) begin
                    nxt_r.state = ST_RUN;
                end else if (r_ff.cnt == 16'h0000) begin
                    nxt_r.state = (t == RESP_RETRY) ? ST_LATCH : ST_HOLD;
                end else if (switchCycleStart) begin
                    nxt_r.cnt = r_ff.cnt - 16'h0001;
                end
            end
            ST_LATCH: begin
                if (pwrOnRise) begin
                    nxt_r.softStart = 1'b1;
                    nxt_r.retries = 3'h0;
                    nxt_r.state = ST_RUN;
                end
            end
            ST_HOLD: begin
                // Can stall forever if the flag never clears
                if (!raw[r_ff.src]) begin
                    nxt_r.state = ST_RUN;
                end
            end
        endcase
        // Line below turn-off overrides everything and restarts softly
        if (r_ff.syncB[7]) begin
            nxt_r.state = ST_DELAY;
            nxt_r.cnt = 16'h0000;
        end
        nxt_r.off = (nxt_r.state == ST_DELAY) || (nxt_r.state == ST_LATCH);
        nxt_r.pwmOff = nxt_r.off || (nxt_r.state == ST_HOLD);
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r_ff <= '0;
            r_ff.state <= ST_RUN;
            r_ff.lineGood <= 1'b1;
            for (int i = 0; i < NSRC; i++) begin
                r_ff.act[i] <= `FFR_ACT_RST;
            end
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign cmdRdData = r_ff.rdData;
    assign pwmTerminate = r_ff.pwmTerm;
    assign pwmDisable = r_ff.pwmOff;
    assign supplyOff = r_ff.off;
    assign softStartReq = r_ff.softStart;
    assign summaryOutOv = r_ff.sumOv;
    assign line_good_flag = r_ff.lineGood;
    assign open_loop_flag = r_ff.openLoop;

    // ==========================================
    // Assertions
    property p_vout;
        @(posedge sys_clk) disable iff (reset)
        r_ff.syncB[0] |=> r_ff.statVout[7];
    endproperty
    a_vout: assert property (p_vout) else $error("vout fault bit missing");
    property p_lineov;
        @(posedge sys_clk) disable iff (reset) r_ff.syncB[4] |=> r_ff.statIn[7];
    endproperty
    a_lineov: assert property (p_lineov) else $error("line ov bit missing");
    property p_below;
        @(posedge sys_clk) disable iff (reset)
        r_ff.syncB[7] |=> supplyOff && !line_good_flag;
    endproperty
    a_below: assert property (p_below) else $error("no shutdown below turn-off");
    property p_oc;
        @(posedge sys_clk) disable iff (reset) r_ff.syncB[8] |=> r_ff.statIn[2];
    endproperty
    a_oc: assert property (p_oc) else $error("input oc bit missing");
    property p_ot;
        @(posedge sys_clk) disable iff (reset) $rose(r_ff.syncB[11]) |=> r_ff.statTemp[7];
    endproperty
    a_ot: assert property (p_ot) else $error("ot bit missing");
    property p_idle;
        @(posedge sys_clk) disable iff (reset)
        r_ff.state == ST_RUN && !found && !r_ff.syncB[7] |=> r_ff.state == ST_RUN;
    endproperty
    a_idle: assert property (p_idle) else $error("left run with no fault");
    property p_hold;
        @(posedge sys_clk) disable iff (reset)
        r_ff.state == ST_HOLD && raw[r_ff.src] && !r_ff.syncB[7] |=> pwmDisable;
    endproperty
    a_hold: assert property (p_hold) else $error("pwm not held off");
    property p_term;
        @(posedge sys_clk) disable iff (reset)
        current_limit_pin |-> ##3 pwmTerminate;
    endproperty
    a_term: assert property (p_term) else $error("pulse not terminated");
    property p_latch;
        @(posedge sys_clk) disable iff (reset)
        r_ff.state == ST_LATCH && !pwrOnRise && !r_ff.syncB[7] |=> supplyOff;
    endproperty
    a_latch: assert property (p_latch) else $error("latched off released");
    property p_sumov;
        @(posedge sys_clk) disable iff (reset)
        (r_ff.syncB[0] || r_ff.syncB[14]) |=> summaryOutOv;
    endproperty
    a_sumov: assert property (p_sumov) else $error("summary ov missing");
    property p_restart;
        @(posedge sys_clk) disable iff (reset) softStartReq |-> $past(supplyOff);
    endproperty
    a_restart: assert property (p_restart) else $error("soft start while running");
    property p_waitsw;
        @(posedge sys_clk) disable iff (reset)
        r_ff.state == ST_WAITSW && raw[r_ff.src] && r_ff.cnt != 16'h0000 && !r_ff.syncB[7]
            |=> r_ff.state == ST_WAITSW;
    endproperty
    a_waitsw: assert property (p_waitsw) else $error("left switch wait early");
    c_waitsw: cover property (@(posedge sys_clk) r_ff.state == ST_WAITSW ##1 r_ff.state == ST_HOLD);
    c_hold: cover property (@(posedge sys_clk) r_ff.state == ST_HOLD);
    c_latch: cover property (@(posedge sys_clk) r_ff.state == ST_LATCH ##[1:50] softStartReq);
    c_delay: cover property (@(posedge sys_clk) r_ff.state == ST_DELAY ##1 softStartReq);
endmodule : ffr_ctrl

//--- sim/ffr_far_model.sv
/*
 Far side of the fault controller: the supply's comparators, the
 power-on request and the PWM timing. Assumes the bench calls its tasks
 at falling edges of sys_clk.
*/
`timescale 1ns/1ns
module ffr_far_model (
    input wire logic sys_clk,
    output logic [15:0] cond,
    output logic [11:0] ovSense,
    output logic [11:0] fbSense,
    output logic swPulse
);
    logic [2:0] swCnt;
    // ==========================================
    // Quiet supply at time zero
    initial begin
        cond = 16'h0000;
        ovSense = 12'h800;
        fbSense = 12'h800;
        swCnt = 3'h0;
        swPulse = 1'b0;
    end
    // Switching cycle pulse every eight clocks, free running like a real PWM
    always @(negedge sys_clk) begin
        swCnt <= swCnt + 3'h1;
        swPulse <= (swCnt == 3'h7);
    end
    // One comparator or request level
    task automatic setCond(input int idx, input logic val);
        cond[idx] = val;
    endtask : setCond
    // Sense codes, offset from mid scale
    task automatic setSense(input logic [11:0] ov, input logic [11:0] fb);
        ovSense = ov;
        fbSense = fb;
    endtask : setSense
endmodule : ffr_far_model

//--- sim/tb_top.sv
/*
 Self-checking bench of the fault controller through its command port.
 Assumes ffr_ctrl, ffr_far_model and ffr_consts.svh are compiled alongside.
*/
`timescale 1ns/1ns
`include "ffr_consts.svh"
module tb_top;
    logic sys_clk, reset, cmdWrite, cmdRead;
    logic [15:0] cmdAddr, cond;
    logic [7:0] cmdWrData, cmdRdData, rdVal;
    logic [11:0] ovSense, fbSense;
    logic swPulse, pwmTerminate, pwmDisable, supplyOff, softStartReq;
    logic summaryOutOv, line_good_flag, open_loop_flag;
    int errorCnt, numChecks, ssCnt, ss0;
    logic [15:0] actAddr [12] = '{`FFR_A_OUT_OV, `FFR_A_OUT_UV, `FFR_A_OT, `FFR_A_IN_OV,
        `FFR_A_IN_UV, `FFR_A_IN_OC, `FFR_A_PCL, `FFR_A_PIN_OV, `FFR_A_OPEN_LOOP,
        `FFR_A_PCL, `FFR_A_PIN_OV, `FFR_A_OPEN_LOOP};
    int stBit [13] = '{7, 6, 5, 4, 7, 5, 4, 3, 2, 1, 0, 7, 6};
    // Fast-flag cases: register, comparator, value, latched off expected
    logic [15:0] fAddr [4] = '{`FFR_A_PCL, `FFR_A_PCL, `FFR_A_PIN_OV, `FFR_A_PIN_OV};
    int fIdx [4] = '{13, 13, 14, 14};
    logic [7:0] fVal [4] = '{8'hd0, 8'h90, 8'hc0, 8'h80};
    logic fLat [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    // ==========================================
    // Clock, parts and soft start counter
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    ffr_far_model far (.sys_clk(sys_clk), .cond(cond), .ovSense(ovSense),
        .fbSense(fbSense), .swPulse(swPulse));
    // Short delay step keeps restart waits to a few clocks
    ffr_ctrl #(.DELAY_STEP_CYC(16'h0002)) dut (.sys_clk(sys_clk), .reset(reset),
        .outOvFaultIn(cond[0]), .outOvWarnIn(cond[1]), .outUvWarnIn(cond[2]),
        .outUvFaultIn(cond[3]), .lineOvFaultIn(cond[4]), .lineUvWarnIn(cond[5]),
        .lineUvFaultIn(cond[6]), .input_below_turnoff(cond[7]), .inOcFaultIn(cond[8]),
        .inOcWarnIn(cond[9]), .inOpWarnIn(cond[10]), .otFaultIn(cond[11]),
        .otWarnIn(cond[12]), .current_limit_pin(cond[13]), .pinOvIn(cond[14]),
        .power_on_request(cond[15]), .ovSenseCode(ovSense), .feedback_sense_pin(fbSense),
        .switchCycleStart(swPulse), .cmdAddr(cmdAddr), .cmdWrite(cmdWrite),
        .cmdRead(cmdRead), .cmdWrData(cmdWrData), .cmdRdData(cmdRdData),
        .pwmTerminate(pwmTerminate), .pwmDisable(pwmDisable), .supplyOff(supplyOff),
        .softStartReq(softStartReq), .summaryOutOv(summaryOutOv),
        .line_good_flag(line_good_flag), .open_loop_flag(open_loop_flag));
    // Counted mid-cycle so the pulse is never read at the edge that launches it
    always @(negedge sys_clk) if (softStartReq === 1'b1) ssCnt <= ssCnt + 1;
    // ==========================================
    // Tasks
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cmdAddr = a;
        cmdWrData = d;
        cmdWrite = 1'b1;
        cyc(1);
        cmdWrite = 1'b0;
        cyc(1);
    endtask : wr
    // Read data is registered, so it is taken a full cycle after the request
    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        cmdAddr = a;
        cmdRead = 1'b1;
        cyc(1);
        cmdRead = 1'b0;
        cyc(1);
        chk("cmdRdData", cmdRdData, exp);
    endtask : rdChk
    // Comparator levels pass a synchroniser, so give them six clocks to land
    task automatic setC(input int i, input logic v);
        far.setCond(i, v);
        cyc(6);
    endtask : setC
    task automatic powerOn();
        setC(15, 1'b1);
        setC(15, 1'b0);
    endtask : powerOn
    task automatic stopTest();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stopTest
    // ==========================================
    // Watchdog, far beyond the several hundred clocks the tests need
    initial begin
        #200000;
        errorCnt++;
        stopTest();
    end
    // ==========================================
    // Test sequence
    initial begin
        errorCnt = 0;
        numChecks = 0;
        ssCnt = 0;
        reset = 1'b1;
        cmdWrite = 1'b0;
        cmdRead = 1'b0;
        cmdAddr = 16'h0000;
        cmdWrData = 8'h00;
        cyc(12);
        reset = 1'b0;
        chk("lineGood", line_good_flag, 8'h01);
        for (int i = 0; i < 9; i++) rdChk(actAddr[i], `FFR_ACT_RST);
        // Type field stays 00 so the fields can vary without actions
        for (int i = 0; i < 9; i++) wr(actAddr[i], {2'b00, 6'(i * 5 + 1)});
        for (int i = 0; i < 9; i++) rdChk(actAddr[i], {2'b00, 6'(i * 5 + 1)});
        wr(`FFR_A_ST_IN, 8'hff);
        rdChk(`FFR_A_ST_IN, 8'h00);
        rdChk(16'h0099, 8'h00);
        // Each status condition alone, all responses set to ignore
        for (int i = 0; i < 13; i++) begin
            ss0 = ssCnt;
            setC(i, 1'b1);
            rdChk(i < 4 ? `FFR_A_ST_VOUT : i < 11 ? `FFR_A_ST_IN : `FFR_A_ST_TEMP,
                8'h01 << stBit[i]);
            chk("supplyOff", supplyOff, 8'(i == 7));
            chk("lineGood", line_good_flag, 8'(i != 7));
            chk("ovSummary", summaryOutOv, 8'(i == 0));
            setC(i, 1'b0);
            chk("softStart", 8'(ssCnt - ss0), 8'(i == 7));
        end
        setC(13, 1'b1);
        chk("pwmTerm", pwmTerminate, 8'h01);
        chk("pwmDis", pwmDisable, 8'h00);
        setC(13, 1'b0);
        chk("pwmTerm", pwmTerminate, 8'h00);
        setC(14, 1'b1);
        chk("ovSummary", summaryOutOv, 8'h01);
        setC(14, 1'b0);
        // Open loop just above the threshold in both signs, and at it with a positive difference
        far.setSense(12'h90f, 12'h800);
        cyc(4);
        chk("openLoop", open_loop_flag, 8'h01);
        far.setSense(12'h90e, 12'h800);
        cyc(4);
        chk("openLoop", open_loop_flag, 8'h00);
        far.setSense(12'h800, 12'h90f);
        cyc(4);
        chk("openLoop", open_loop_flag, 8'h01);
        far.setSense(12'h800, 12'h800);
        cyc(4);
        // Disable beats retry; retry served after; retries run out
        wr(`FFR_A_OT, 8'hc0);
        wr(`FFR_A_OUT_UV, 8'h89);
        far.setCond(3, 1'b1);
        setC(11, 1'b1);
        chk("pwmDis", pwmDisable, 8'h01);
        chk("supplyOff", supplyOff, 8'h00);
        ss0 = ssCnt;
        setC(11, 1'b0);
        chk("supplyOff", supplyOff, 8'h01);
        cyc(20);
        chk("softStart", 8'(ssCnt - ss0), 8'h01);
        setC(3, 1'b0);
        chk("supplyOff", supplyOff, 8'h01);
        powerOn();
        chk("softStart", 8'(ssCnt - ss0), 8'h02);
        chk("supplyOff", supplyOff, 8'h00);
        // Equal type: zero retries wins, so it latches without restart
        wr(`FFR_A_OT, 8'h81);
        wr(`FFR_A_OUT_UV, 8'h99);
        ss0 = ssCnt;
        far.setCond(3, 1'b1);
        setC(11, 1'b1);
        cyc(20);
        chk("softStart", 8'(ssCnt - ss0), 8'h00);
        chk("supplyOff", supplyOff, 8'h01);
        far.setCond(3, 1'b0);
        setC(11, 1'b0);
        powerOn();
        wr(`FFR_A_OT, 8'h00);
        wr(`FFR_A_OUT_UV, 8'h00);
        // Debounced type 01: one retry, then latched off
        wr(`FFR_A_OT, 8'h49);
        ss0 = ssCnt;
        setC(11, 1'b1);
        cyc(20);
        chk("softStart", 8'(ssCnt - ss0), 8'h01);
        chk("supplyOff", supplyOff, 8'h01);
        setC(11, 1'b0);
        powerOn();
        wr(`FFR_A_OT, 8'h00);
        // Fast flags: disable until clear, or latch until power-on request
        for (int k = 0; k < 4; k++) begin
            wr(fAddr[k], fVal[k]);
            setC(fIdx[k], 1'b1);
            cyc(12);
            chk("pwmDis", pwmDisable, 8'h01);
            chk("supplyOff", supplyOff, 8'(fLat[k]));
            setC(fIdx[k], 1'b0);
            chk("supplyOff", supplyOff, 8'(fLat[k]));
            powerOn();
            chk("pwmDis", pwmDisable, 8'h00);
            wr(fAddr[k], 8'h00);
        end
        // Fast flag type 01: pin overvoltage, then pulse limit, restart after delay
        for (int k = 0; k < 2; k++) begin
            wr(k == 0 ? `FFR_A_PIN_OV : `FFR_A_PCL, 8'h40);
            ss0 = ssCnt;
            setC(k == 0 ? 14 : 13, 1'b1);
            setC(k == 0 ? 14 : 13, 1'b0);
            cyc(10);
            chk("restarted", 8'(ssCnt > ss0), 8'h01);
            chk("supplyOff", supplyOff, 8'h00);
            wr(k == 0 ? `FFR_A_PIN_OV : `FFR_A_PCL, 8'h00);
        end
        stopTest();
    end
endmodule : tb_top
